/* ctma_defs.vh */
// Register addresses, reset values and widths for the CAN timer and message access block
`ifndef CTMA_DEFS_VH
`define CTMA_DEFS_VH
// ----------------------------------------------------------------------
// Special function register addresses
// ----------------------------------------------------------------------
`define CTMA_ADDR_PRESCALE 8'hA1
`define CTMA_ADDR_MSG_DATA 8'hA3
`define CTMA_ADDR_TTC_LOW 8'hA4
`define CTMA_ADDR_TTC_HIGH 8'hA5
`define CTMA_ADDR_TIM_LOW 8'hAC
`define CTMA_ADDR_TIM_HIGH 8'hAD
`define CTMA_ADDR_STAMP_LOW 8'hAE
`define CTMA_ADDR_STAMP_HIGH 8'hAF
// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define CTMA_RST_BYTE 8'h00
`define CTMA_RST_WORD 16'h0000
`define CTMA_RST_IDX 3'h0
`define CTMA_IDX_STEP 3'h1
`define CTMA_CNT_STEP 8'h01
`define CTMA_WORD_STEP 16'h0001
`define CTMA_HI 15:8
`define CTMA_LO 7:0
`endif

/* ctma_top.v */
// CAN message timer, prescaler, stamp and message data window registers
`timescale 1ns/10ps
`include "ctma_defs.vh"

// How it works
// [R1] A byte window reads or writes one data byte of the selected message object.
// [R2] With auto-increment on, byte index advances after each window access without a same-cycle index load, wrapping 7 to 0.
// [R3] Eight-bit prescaler value 0..255 divides the clock of the whole 16-bit message timer.
// [R4] Timer high byte is read only; writes leave the count unchanged.
// [R5] Timer low byte is a separate read-only register.
// [R6] Reset clears message timer and scheduling timer byte registers to zero.
// [R7] Frame stamp high byte is read through a read-only register.
// [R8] Frame stamp low byte is read through a read-only register.
// [R9] Software must not assume window or stamp contents after reset.
// [R10] Scheduling timer high byte is read through a read-only register.
// [R11] Scheduling timer low byte is read through a read-only register.
module ctma_top #(
   parameter DATA_W = 8
) (
   // Clock and reset
   input wire mclk_i,
   input wire rst_i,
   // Special function register port
   input wire [7:0] sfr_addr_i,
   input wire [DATA_W-1:0] sfr_wdata_i,
   input wire sfr_wr_i,
   input wire sfr_rd_i,
   output reg [DATA_W-1:0] sfr_rdata_o,
   // Message object store, one byte per cycle
   input wire auto_inc_i,
   input wire idx_load_i,
   input wire [2:0] idx_val_i,
   input wire [DATA_W-1:0] msg_rdata_i,
   output reg [2:0] msg_idx_o,
   output reg [DATA_W-1:0] msg_wdata_o,
   output reg msg_wr_o,
   // Timer events and external timers
   input wire stamp_capture_i,
   input wire [15:0] sched_timer_value_i,
   output reg [15:0] message_timer_count_o
);

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   function hit;
      input [7:0] a;
      input [7:0] ref_a;
      begin
         hit = (a == ref_a);
      end
   endfunction

   wire win_acc = hit(sfr_addr_i, `CTMA_ADDR_MSG_DATA) & (sfr_wr_i | sfr_rd_i);

   // ----------------------------------------------------------------------
   // Prescaler and message timer
   // ----------------------------------------------------------------------
   reg [7:0] timer_divider_value_q;
   reg [7:0] presc_cnt_q;
   reg [15:0] tim_q;
   reg [15:0] frame_stamp_value_q;
   reg [15:0] sched_q;
   reg [2:0] idx_q;

   // [R3] prescaler divide
   wire presc_tick = (presc_cnt_q == timer_divider_value_q);

   always @(posedge mclk_i) begin
      if (rst_i) begin
         timer_divider_value_q <= `CTMA_RST_BYTE;
         presc_cnt_q <= `CTMA_RST_BYTE;
         // [R6] timers cleared
         tim_q <= `CTMA_RST_WORD;
         sched_q <= `CTMA_RST_WORD;
      end else begin
         if (sfr_wr_i && hit(sfr_addr_i, `CTMA_ADDR_PRESCALE))
            timer_divider_value_q <= sfr_wdata_i[7:0];
         // Divide by value plus one, so zero runs at the full clock
         if (presc_tick)
            presc_cnt_q <= `CTMA_RST_BYTE;
         else
            presc_cnt_q <= presc_cnt_q + `CTMA_CNT_STEP;
         // [R4] writes never touch count
         if (presc_tick)
            tim_q <= tim_q + `CTMA_WORD_STEP;
         sched_q <= sched_timer_value_i;
      end
   end

   // [R9] stamp has no reset value
   always @(posedge mclk_i) begin
      if (stamp_capture_i)
         frame_stamp_value_q <= tim_q;
   end

   // ----------------------------------------------------------------------
   // Message data window
   // ----------------------------------------------------------------------
   always @(posedge mclk_i) begin
      if (rst_i) begin
         idx_q <= `CTMA_RST_IDX;
         msg_wr_o <= 1'b0;
         msg_wdata_o <= {DATA_W{1'b0}};
      end else begin
         // [R1] window write
         msg_wr_o <= win_acc & sfr_wr_i;
         if (win_acc & sfr_wr_i)
            msg_wdata_o <= sfr_wdata_i;
         if (idx_load_i)
            idx_q <= idx_val_i;
         // [R2] cyclic auto-increment
         else if (win_acc && auto_inc_i)
            idx_q <= idx_q + `CTMA_IDX_STEP;
      end
   end

   // ----------------------------------------------------------------------
   // Read mux and registered outputs
   // ----------------------------------------------------------------------
   reg [7:0] rd_d;
   always @* begin
      rd_d = `CTMA_RST_BYTE;
      case (sfr_addr_i)
         `CTMA_ADDR_PRESCALE: rd_d = timer_divider_value_q;
         // [R1] window read
         `CTMA_ADDR_MSG_DATA: rd_d = msg_rdata_i[7:0];
         // [R11] scheduling low
         `CTMA_ADDR_TTC_LOW: rd_d = sched_q[`CTMA_LO];
         // [R10] scheduling high
         `CTMA_ADDR_TTC_HIGH: rd_d = sched_q[`CTMA_HI];
         // [R5] timer low
         `CTMA_ADDR_TIM_LOW: rd_d = tim_q[`CTMA_LO];
         // [R4] timer high
         `CTMA_ADDR_TIM_HIGH: rd_d = tim_q[`CTMA_HI];
         // [R8] stamp low
         `CTMA_ADDR_STAMP_LOW: rd_d = frame_stamp_value_q[`CTMA_LO];
         // [R7] stamp high
         `CTMA_ADDR_STAMP_HIGH: rd_d = frame_stamp_value_q[`CTMA_HI];
         default: rd_d = `CTMA_RST_BYTE;
      endcase
   end

   always @(posedge mclk_i) begin
      if (rst_i) begin
         sfr_rdata_o <= {DATA_W{1'b0}};
         msg_idx_o <= `CTMA_RST_IDX;
         message_timer_count_o <= `CTMA_RST_WORD;
      end else begin
         if (sfr_rd_i)
            sfr_rdata_o <= rd_d;
         msg_idx_o <= idx_q;
         message_timer_count_o <= tim_q;
      end
   end

endmodule // ctma_top

/* ctma_assertions.sv */
// Port-level checker for the CAN timer and message access block
`timescale 1ns/10ps
module ctma_assertions #(parameter DATA_W = 8) (
   input wire mclk_i, rst_i, sfr_wr_i, sfr_rd_i, auto_inc_i, idx_load_i,
   input wire stamp_capture_i, msg_wr_o,
   input wire [7:0] sfr_addr_i,
   input wire [DATA_W-1:0] sfr_wdata_i, sfr_rdata_o, msg_rdata_i, msg_wdata_o,
   input wire [2:0] idx_val_i, msg_idx_o,
   input wire [15:0] sched_timer_value_i, message_timer_count_o
);
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   wire rd_win = sfr_rd_i && sfr_addr_i == 8'hA3;
   wire wr_win = sfr_wr_i && sfr_addr_i == 8'hA3;
   wire [15:0] cnt = message_timer_count_o;
   property p_wr; wr_win |=> msg_wr_o && msg_wdata_o == $past(sfr_wdata_i); endproperty
   a_wr: assert property (p_wr) else $error("window write lost");
   property p_win_rd; rd_win |=> sfr_rdata_o == $past(msg_rdata_i); endproperty
   a_win_rd: assert property (p_win_rd) else $error("window read wrong");
   // Index moves two cycles after the access, so the step is seen between later samples
   property p_inc; (rd_win || wr_win) && auto_inc_i && !idx_load_i
      |=> ##1 msg_idx_o == $past(msg_idx_o) + 3'h1; endproperty
   a_inc: assert property (p_inc) else $error("index did not step");
   property p_load; idx_load_i |=> ##1 msg_idx_o == $past(idx_val_i, 2); endproperty
   a_load: assert property (p_load) else $error("index load wrong");
   property p_step; cnt != $past(cnt) |-> cnt == $past(cnt) + 16'h0001; endproperty
   a_step: assert property (p_step) else $error("timer jumped");
   property p_rst; $fell(rst_i) |-> cnt == 16'h0000 && sfr_rdata_o == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("reset value wrong");
   property p_ttc; sfr_rd_i && sfr_addr_i == 8'hA4 && $stable(sched_timer_value_i)
      |=> sfr_rdata_o == $past(sched_timer_value_i[7:0]); endproperty
   a_ttc: assert property (p_ttc) else $error("sched low wrong");
   property p_tim; $stable(cnt) && sfr_rd_i && sfr_addr_i == 8'hAC ##1 $stable(cnt)
      |-> sfr_rdata_o == cnt[7:0]; endproperty
   a_tim: assert property (p_tim) else $error("timer low wrong");
   c_wr: cover property (wr_win && auto_inc_i);
   c_load: cover property (idx_load_i);
   c_stamp: cover property (stamp_capture_i);
endmodule // ctma_assertions

/* testbench.sv */
// Self-checking testbench for the CAN timer and message access block
`timescale 1ns/10ps
module testbench;
   logic mclk_i = 0, rst_i = 1, sfr_wr_i = 0, sfr_rd_i = 0, auto_inc_i = 1, idx_load_i = 0;
   logic stamp_capture_i = 0, msg_wr_o;
   logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, msg_wdata_o;
   logic [2:0] idx_val_i = 3'h0, msg_idx_o;
   logic [15:0] sched_timer_value_i = 16'hA55A, message_timer_count_o, c0;
   wire [7:0] msg_rdata_i = {5'h18, msg_idx_o};
   int fail_count = 0, cmp_count = 0, i;
   // Rows: write flag, address, write data or expected read data
   logic [16:0] rows [8] = '{17'h1A103, 17'h0A103, 17'h0A45A, 17'h0A5A5,
      17'h1A400, 17'h0A45A, 17'h1ADFF, 17'h0A000};
   ctma_top u_dut (.*);
   initial forever #2 mclk_i = ~mclk_i;
   task chk(input logic [15:0] g, e);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task acc(input logic w, input logic [7:0] a, d);
      @(posedge mclk_i);
      {sfr_wr_i, sfr_rd_i, sfr_addr_i, sfr_wdata_i} <= {w, !w, a, d};
      @(posedge mclk_i);
      {sfr_wr_i, sfr_rd_i} <= 2'h0;
      #1;
   endtask
   task finish_test;
      if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge mclk_i);
      rst_i <= 0;
      acc(0, 8'hAD, 0);
      chk(sfr_rdata_o, 0);
      foreach (rows[k]) begin
         acc(rows[k][16], rows[k][15:8], rows[k][7:0]);
         if (!rows[k][16]) chk(sfr_rdata_o, rows[k][7:0]);
      end
      c0 = message_timer_count_o;
      repeat (40) @(posedge mclk_i);
      #1;
      chk(message_timer_count_o - c0, 10);
      @(posedge mclk_i);
      {idx_load_i, idx_val_i} <= 4'hE;
      @(posedge mclk_i);
      idx_load_i <= 0;
      for (i = 0; i < 9; i++) begin
         acc(1, 8'hA3, 8'h30 + i);
         chk({msg_wr_o, msg_wdata_o}, 9'h130 + i);
      end
      acc(0, 8'hA3, 0);
      chk(sfr_rdata_o, 8'hC7);
      // With auto-increment off the index must hold at zero
      @(posedge mclk_i);
      auto_inc_i <= 0;
      for (i = 0; i < 2; i++) begin
         acc(0, 8'hA3, 0);
         chk(sfr_rdata_o, 8'hC0);
      end
      @(posedge mclk_i);
      auto_inc_i <= 1;
      // Slow timer so the stamp and both bytes are read while it stands still
      acc(1, 8'hA1, 8'hFF);
      c0 = message_timer_count_o;
      for (i = 0; i < 600 && message_timer_count_o === c0; i++) @(posedge mclk_i);
      if (i == 600) begin
         fail_count++;
         finish_test();
      end
      #1;
      c0 = message_timer_count_o;
      // stamp read only after a capture
      @(posedge mclk_i);
      stamp_capture_i <= 1;
      @(posedge mclk_i);
      stamp_capture_i <= 0;
      for (i = 0; i < 4; i++) begin
         acc(0, 8'hAC + i, 0);
         chk(sfr_rdata_o, i[0] ? c0[15:8] : c0[7:0]);
      end
      @(posedge mclk_i);
      rst_i <= 1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 0;
      #1;
      chk(message_timer_count_o, 0);
      chk(sfr_rdata_o, 0);
      finish_test();
   end
endmodule // testbench
bind ctma_top ctma_assertions #(.DATA_W(DATA_W)) u_chk (.*);
